// File: hdl/dcc_top.sv
// Implementation choices: the address map and the Avalon-MM register port.
`default_nettype none
module dcc_top
   import dcc_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic chip_idle,
   input wire logic cmp_a_raw,
   input wire logic cmp_b_raw,
   output logic cmp_a_on,
   output logic cmp_b_on,
   output logic cmp_a_plus_select,
   output logic cmp_a_minus_select,
   output logic cmp_b_plus_select,
   output logic cmp_b_minus_select,
   output logic cmp_a_pad,
   output logic cmp_a_pad_oe,
   output logic cmp_b_pad,
   output logic cmp_b_pad_oe,
   output logic ref_ladder_enable,
   output logic ref_pin_output_enable,
   output logic ref_range_select,
   output logic ref_source_select,
   output logic [3:0] ref_level_code,
   output logic irq
);
   // ==========================================================
   // Reset release
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ==========================================================
   // Comparator channels
   dcc_cmp_if cmp_a ();
   dcc_cmp_if cmp_b ();

   logic [15:0] ctrl_reg;
   logic [15:0] ref_reg;
   logic [1:0] evt_reg;
   logic [1:0] evt_next;
   logic [1:0] istat_reg;
   logic [1:0] istat_next;
   logic [1:0] imask_reg;

   assign cmp_a.enable = ctrl_reg[EN_A_BIT];
   assign cmp_a.invert = ctrl_reg[INV_A_BIT];
   assign cmp_a.raw = cmp_a_raw;
   assign cmp_b.enable = ctrl_reg[EN_B_BIT];
   assign cmp_b.invert = ctrl_reg[INV_B_BIT];
   assign cmp_b.raw = cmp_b_raw;

   dcc_channel chan_a (
      .clock(clock),
      .rst_n(rst_n),
      .cmp(cmp_a)
   );

   dcc_channel chan_b (
      .clock(clock),
      .rst_n(rst_n),
      .cmp(cmp_b)
   );

   // ==========================================================
   // Bus decode
   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [15:0] wmask);
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
      merge16 = (old_v & ~lanes) | (wd[15:0] & lanes);
   endfunction

   logic [3:0] byte_addr;
   logic sel_ctrl;
   logic sel_ref;
   logic sel_stat;
   logic sel_mask;
   logic wr_ctrl;
   logic wr_ref;
   logic wr_stat;
   logic wr_mask;
   logic [1:0] changed;
   logic [1:0] evt_clear;
   logic [1:0] stat_clear;
   logic irq_gate;
   logic [15:0] ctrl_view;
   logic [31:0] rdata_next;
   logic ack_reg;

   assign byte_addr = {avs_address[3:2], 2'b00};
   assign sel_ctrl = (avs_address[4] == 1'b0) && (byte_addr == CTRL_ADDR);
   assign sel_ref = (avs_address[4] == 1'b0) && (byte_addr == REF_ADDR);
   assign sel_stat = (avs_address[4] == 1'b0) && (byte_addr == IRQ_STAT_ADDR);
   assign sel_mask = (avs_address[4] == 1'b0) && (byte_addr == IRQ_MASK_ADDR);
   // One wait cycle then ack; a write takes effect on the ack edge, read data is captured on the edge before it
   assign wr_ctrl = avs_write && ack_reg && sel_ctrl;
   assign wr_ref = avs_write && ack_reg && sel_ref;
   assign wr_stat = avs_write && ack_reg && sel_stat && avs_byteenable[0];
   assign wr_mask = avs_write && ack_reg && sel_mask && avs_byteenable[0];

   assign changed = {cmp_b.changed, cmp_a.changed};
   // Writing zero to an event flag clears it
   assign evt_clear = (wr_ctrl && avs_byteenable[1]) ?
                      ~{avs_writedata[EVT_B_BIT], avs_writedata[EVT_A_BIT]} : 2'b00;
   assign evt_next = (evt_reg & ~evt_clear) | changed;

   // Idle suppression blocks new interrupt status only
   assign irq_gate = ~(ctrl_reg[IDLE_SUP_BIT] & chip_idle);
   assign stat_clear = wr_stat ? avs_writedata[1:0] : 2'b00;
   assign istat_next = (istat_reg & ~stat_clear) | (changed & {2{irq_gate}});

   assign ctrl_view = {ctrl_reg[15], 1'b0, evt_reg, ctrl_reg[11:8],
                       cmp_b.result, cmp_a.result, ctrl_reg[5:0]};
   assign rdata_next = sel_ctrl ? {16'h0000, ctrl_view} :
                       sel_ref ? {16'h0000, 8'h00, ref_reg[7:0]} :
                       sel_stat ? {30'h0000_0000, istat_reg} :
                       sel_mask ? {30'h0000_0000, imask_reg} : UNMAPPED_DATA;

   // ==========================================================
   // Registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= UNMAPPED_DATA;
      end else begin
         ack_reg <= (avs_read || avs_write) && !ack_reg;
         // Registered so the bus sees a clean flop output
         avs_waitrequest <= ~((avs_read || avs_write) && !ack_reg);
         if (avs_read && !ack_reg) begin
            avs_readdata <= rdata_next;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= CTRL_RESET;
         ref_reg <= REF_RESET;
         evt_reg <= 2'b00;
         istat_reg <= IRQ_RESET;
         imask_reg <= IRQ_RESET;
      end else begin
         evt_reg <= evt_next;
         istat_reg <= istat_next;
         if (wr_ctrl) begin
            ctrl_reg <= merge16(ctrl_reg, avs_writedata, avs_byteenable, CTRL_WMASK);
         end
         if (wr_ref) begin
            ref_reg <= merge16(ref_reg, avs_writedata, avs_byteenable, REF_WMASK);
         end
         if (wr_mask) begin
            imask_reg <= avs_writedata[1:0];
         end
      end
   end

   // ==========================================================
   // Registered outputs toward the analog cells
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmp_a_on <= 1'b0;
         cmp_b_on <= 1'b0;
         cmp_a_plus_select <= 1'b0;
         cmp_a_minus_select <= 1'b0;
         cmp_b_plus_select <= 1'b0;
         cmp_b_minus_select <= 1'b0;
         cmp_a_pad <= 1'b0;
         cmp_a_pad_oe <= 1'b0;
         cmp_b_pad <= 1'b0;
         cmp_b_pad_oe <= 1'b0;
         ref_ladder_enable <= 1'b0;
         ref_pin_output_enable <= 1'b0;
         ref_range_select <= 1'b0;
         ref_source_select <= 1'b0;
         ref_level_code <= 4'h0;
         irq <= 1'b0;
      end else begin
         cmp_a_on <= ctrl_reg[EN_A_BIT];
         cmp_b_on <= ctrl_reg[EN_B_BIT];
         cmp_a_plus_select <= ctrl_reg[PLUS_A_BIT];
         cmp_a_minus_select <= ctrl_reg[MINUS_A_BIT];
         cmp_b_plus_select <= ctrl_reg[PLUS_B_BIT];
         cmp_b_minus_select <= ctrl_reg[MINUS_B_BIT];
         cmp_a_pad <= cmp_a.result;
         cmp_a_pad_oe <= ctrl_reg[PAD_A_BIT];
         cmp_b_pad <= cmp_b.result;
         cmp_b_pad_oe <= ctrl_reg[PAD_B_BIT];
         ref_ladder_enable <= ref_reg[REF_EN_BIT];
         ref_pin_output_enable <= ref_reg[REF_OE_BIT];
         ref_range_select <= ref_reg[REF_RANGE_BIT];
         ref_source_select <= ref_reg[REF_SRC_BIT];
         // Ladder taps decode the code itself; the divide ratio is analog
         ref_level_code <= ref_reg[3:0];
         irq <= |(istat_next & imask_reg);
      end
   end
endmodule
`default_nettype wire

// File: hdl/dcc_pkg.sv
`default_nettype none
package dcc_pkg;
   // ==========================================================
   // Register map (byte addresses of 32-bit words)
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] REF_ADDR = 4'h4;
   localparam logic [3:0] IRQ_STAT_ADDR = 4'h8;
   localparam logic [3:0] IRQ_MASK_ADDR = 4'hc;
   // ==========================================================
   // Control register fields
   localparam int IDLE_SUP_BIT = 15;
   localparam int EVT_B_BIT = 13;
   localparam int EVT_A_BIT = 12;
   localparam int EN_B_BIT = 11;
   localparam int EN_A_BIT = 10;
   localparam int PAD_B_BIT = 9;
   localparam int PAD_A_BIT = 8;
   localparam int RES_B_BIT = 7;
   localparam int RES_A_BIT = 6;
   localparam int INV_B_BIT = 5;
   localparam int INV_A_BIT = 4;
   localparam int MINUS_B_BIT = 3;
   localparam int PLUS_B_BIT = 2;
   localparam int MINUS_A_BIT = 1;
   localparam int PLUS_A_BIT = 0;
   // Writable control bits; 14 and the read-only results excluded
   localparam logic [15:0] CTRL_WMASK = 16'hbf3f;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // ==========================================================
   // Reference register fields
   localparam int REF_EN_BIT = 7;
   localparam int REF_OE_BIT = 6;
   localparam int REF_RANGE_BIT = 5;
   localparam int REF_SRC_BIT = 4;
   localparam logic [15:0] REF_WMASK = 16'h00ff;
   localparam logic [15:0] REF_RESET = 16'h0000;
   // Interrupt status layout: bit 0 comparator a, bit 1 comparator b
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage
`default_nettype wire

// File: hdl/dcc_cmp_if.sv
`default_nettype none
interface dcc_cmp_if;
   logic enable;
   logic invert;
   logic raw;
   logic result;
   logic changed;
   modport ctl (output enable, output invert, output raw, input result, input changed);
   modport chan (input enable, input invert, input raw, output result, output changed);
endinterface
`default_nettype wire

// File: hdl/dcc_channel.sv
`default_nettype none
module dcc_channel
   import dcc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   dcc_cmp_if.chan cmp
);
   // ==========================================================
   // Result tracking
   logic result_reg;
   logic result_next;
   logic changed_reg;

   // Disabled comparator holds low, so enabling it flags a change when raw ^ invert is already high
   assign result_next = cmp.enable & (cmp.raw ^ cmp.invert);
   assign cmp.result = result_reg;
   assign cmp.changed = changed_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= 1'b0;
         changed_reg <= 1'b0;
      end else begin
         result_reg <= result_next;
         changed_reg <= cmp.enable & (result_next != result_reg);
      end
   end
endmodule
`default_nettype wire

// File: verification/dcc_sva.sv
`default_nettype none
module dcc_sva (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic cmp_a_raw,
   input wire logic cmp_a_on,
   input wire logic cmp_b_on,
   input wire logic cmp_a_plus_select,
   input wire logic cmp_a_minus_select,
   input wire logic cmp_b_plus_select,
   input wire logic cmp_b_minus_select,
   input wire logic cmp_a_pad,
   input wire logic cmp_a_pad_oe,
   input wire logic cmp_b_pad_oe,
   input wire logic ref_ladder_enable,
   input wire logic ref_pin_output_enable,
   input wire logic ref_range_select,
   input wire logic ref_source_select,
   input wire logic [3:0] ref_level_code
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // Write capture
   logic ack;
   logic [31:0] wd_q;
   assign ack = avs_write && !avs_waitrequest;
   always_ff @(posedge clock) if (ack) wd_q <= avs_writedata;
   sequence ctrl_wr;
      ack && avs_address == 5'h0 && (&avs_byteenable[1:0]);
   endsequence
   sequence ref_wr;
      ack && avs_address == 5'h4 && avs_byteenable[0];
   endsequence
   // ==========================================================
   // Properties
   wait_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no ack after wait cycle");
   ack_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("ack without request");
   pad_oe_a: assert property (ctrl_wr |-> ##[1:2] {cmp_b_pad_oe, cmp_a_pad_oe} == wd_q[9:8])
      else $error("pad enable wrong");
   enable_a: assert property (ctrl_wr |-> ##[1:2] {cmp_b_on, cmp_a_on} == wd_q[11:10])
      else $error("enable wrong");
   select_a: assert property (ctrl_wr |-> ##[1:2] {cmp_b_minus_select, cmp_b_plus_select,
      cmp_a_minus_select, cmp_a_plus_select} == wd_q[3:0]) else $error("input select wrong");
   ref_a: assert property (ref_wr |-> ##[1:2] {ref_ladder_enable, ref_pin_output_enable,
      ref_range_select, ref_source_select, ref_level_code} == wd_q[7:0])
      else $error("reference field wrong");
   pad_follow_a: assert property (cmp_a_on && !avs_write && $changed(cmp_a_raw)
      |-> ##[1:4] $changed(cmp_a_pad)) else $error("pad did not follow result");
   unmapped_a: assert property (ack && avs_address[4]
      |=> $stable({cmp_a_on, cmp_b_on, ref_level_code})) else $error("unmapped write acted");
endmodule
bind dcc_top dcc_sva chk_i (.*);
`default_nettype wire

// File: verification/dcc_cmp_model.sv
`default_nettype none
module dcc_cmp_model (
   input wire logic on,
   input wire logic plus_sel,
   input wire logic minus_sel,
   input wire logic lad_en,
   input wire logic rng,
   input wire logic [3:0] code,
   input wire logic [7:0] pin_p,
   input wire logic [7:0] pin_m,
   output logic raw
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels in units of supply/96, so both step sizes stay whole
   logic [7:0] vref, vp, vm;
   assign vref = !lad_en ? 8'h0 : rng ? {2'h0, code, 2'h0} : 8'h18 + 8'(code) * 8'h3;
   assign vp = plus_sel ? pin_p : vref;
   assign vm = minus_sel ? pin_p : pin_m;
   // Cell switched off rests low
   assign raw = on && (vp > vm);
endmodule
`default_nettype wire

// File: verification/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, arst_n, avs_read, avs_write, avs_waitrequest, chip_idle, irq;
   logic cmp_a_raw, cmp_b_raw, cmp_a_on, cmp_b_on, cmp_a_pad, cmp_a_pad_oe, cmp_b_pad, cmp_b_pad_oe;
   logic cmp_a_plus_select, cmp_a_minus_select, cmp_b_plus_select, cmp_b_minus_select;
   logic ref_ladder_enable, ref_pin_output_enable, ref_range_select, ref_source_select;
   logic [3:0] ref_level_code, avs_byteenable;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [7:0] pin_p, pin_m;
   int mismatches, n_compared;
   dcc_top uut (.*);
   dcc_cmp_model mod_a (.on(cmp_a_on), .plus_sel(cmp_a_plus_select), .minus_sel(cmp_a_minus_select),
      .lad_en(ref_ladder_enable), .rng(ref_range_select), .code(ref_level_code), .pin_p(pin_p),
      .pin_m(pin_m), .raw(cmp_a_raw));
   dcc_cmp_model mod_b (.on(cmp_b_on), .plus_sel(cmp_b_plus_select), .minus_sel(cmp_b_minus_select),
      .lad_en(ref_ladder_enable), .rng(ref_range_select), .code(ref_level_code), .pin_p(pin_p),
      .pin_m(pin_m), .raw(cmp_b_raw));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ==========================================================
   // Bus and checking
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Request held until the rising edge that samples waitrequest low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      for (int i = 0; i <= 16; i += 4) begin
         rd(5'(i));
         chk(q, 32'h0);
      end
      wr(5'h0, 32'hf3cf);
      wr(5'h10, 32'hffff);
      rd(5'h0);
      chk(q, 32'h830f);
      chk({cmp_b_pad_oe, cmp_a_pad_oe, cmp_b_on, cmp_a_on}, 4'hc);
      chk({cmp_b_minus_select, cmp_b_plus_select, cmp_a_minus_select, cmp_a_plus_select}, 4'hf);
      wr(5'h4, 32'hffff);
      rd(5'h4);
      chk(q, 32'hff);
      chk({ref_ladder_enable, ref_pin_output_enable, ref_range_select, ref_source_select}, 4'hf);
      $display("test regs done");
   endtask
   task automatic t_event();
      wr(5'hc, 32'h3);
      wr(5'h4, 32'haf);
      wr(5'h0, 32'h400);
      rd(5'h0);
      chk(q, 32'h400);
      wr(5'h4, 32'h8f);
      repeat (4) @(posedge clock);
      rd(5'h0);
      chk(q, 32'h1440);
      chk({irq, cmp_a_pad}, 2'h3);
      wr(5'h0, 32'h410);
      repeat (4) @(posedge clock);
      rd(5'h0);
      chk(q, 32'h1410);
      chk(cmp_a_pad, 1'b0);
      wr(5'h0, 32'h410);
      rd(5'h0);
      chk(q, 32'h410);
      wr(5'h8, 32'h1);
      rd(5'h8);
      chk({q, irq}, 33'h0);
      $display("test event done");
   endtask
   task automatic t_idle();
      chip_idle <= 1'b1;
      wr(5'h0, 32'h8410);
      wr(5'h4, 32'haf);
      repeat (4) @(posedge clock);
      rd(5'h0);
      chk(q, 32'h9450);
      rd(5'h8);
      chk({q, irq}, 33'h0);
      chip_idle <= 1'b0;
      wr(5'h4, 32'h8f);
      repeat (4) @(posedge clock);
      rd(5'h8);
      chk({q, irq}, 33'h3);
      wr(5'hc, 32'h0);
      rd(5'h8);
      chk({q, irq}, 33'h2);
      $display("test idle done");
   endtask
   task automatic t_second();
      wr(5'h8, 32'h1);
      wr(5'hc, 32'h3);
      wr(5'h0, 32'h808);
      repeat (4) @(posedge clock);
      rd(5'h0);
      chk(q, 32'h2888);
      rd(5'h8);
      chk({q, irq, cmp_b_pad}, 34'hb);
      $display("test second done");
   endtask
   initial begin
      {arst_n, avs_read, avs_write, chip_idle} = 4'h0;
      avs_address = 5'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      pin_p = 8'h32;
      pin_m = 8'h3e;
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      t_regs();
      t_event();
      t_idle();
      t_second();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      final_report();
   end
endmodule
`default_nettype wire
